// file: pap_pkg.sv
package pap_pkg;
    localparam int SAMP_W     = 16;
    localparam int GAIN_W     = 12;
    localparam int GMUL_W     = 14;
    localparam int CUR_W      = 18;
    localparam int BUS_W      = 28;
    localparam int TERM_W     = 31;
    localparam int TOTAL_W    = 33;
    localparam int ACC_W      = 54;
    localparam int EOUT_W     = 24;
    localparam int REG_AW     = 4;
    localparam int REG_DW     = 16;
    localparam int NUM_W      = 12;
    localparam int FIFO_DEPTH = 8;
    localparam int GAIN_FRAC  = 12;
    localparam int PROD_SHIFT = 6;
    localparam int LPF_SHIFT  = 4;

    localparam logic signed [GMUL_W-1:0] GAIN_UNITY = 14'sh1000;

    localparam logic [REG_AW-1:0] ADDR_OFS_A  = 4'h0;
    localparam logic [REG_AW-1:0] ADDR_OFS_B  = 4'h1;
    localparam logic [REG_AW-1:0] ADDR_OFS_C  = 4'h2;
    localparam logic [REG_AW-1:0] ADDR_MODE   = 4'h3;
    localparam logic [REG_AW-1:0] ADDR_PG_A   = 4'h4;
    localparam logic [REG_AW-1:0] ADDR_PG_B   = 4'h5;
    localparam logic [REG_AW-1:0] ADDR_PG_C   = 4'h6;
    localparam logic [REG_AW-1:0] ADDR_WG_A   = 4'h7;
    localparam logic [REG_AW-1:0] ADDR_WG_B   = 4'h8;
    localparam logic [REG_AW-1:0] ADDR_WG_C   = 4'h9;
    localparam logic [REG_AW-1:0] ADDR_NUMER  = 4'ha;

    localparam int MODE_LSB  = 6;
    localparam int MODE_MSB  = 7;
    localparam int EN_C_BIT  = 3;
    localparam int EN_B_BIT  = 4;
    localparam int EN_A_BIT  = 5;
    localparam int REV_A_BIT = 12;
    localparam int REV_B_BIT = 13;
    localparam int REV_C_BIT = 14;
    localparam int MODE_REG_W = 8;

    localparam logic [MODE_REG_W-1:0] MODE_RESET = 8'h38;
    localparam logic [GAIN_W-1:0]     GAIN_RESET = 12'h000;
    localparam logic [GAIN_W-1:0]     OFS_RESET  = 12'h000;
    localparam logic [NUM_W-1:0]      NUM_RESET  = 12'h000;

    typedef enum logic [1:0] {
        PAP_SUM3    = 2'h0,
        PAP_DIFF_AC = 2'h1,
        PAP_DIFF_A  = 2'h2,
        PAP_RSVD    = 2'h3
    } pap_mode_t;
endpackage

// file: pap_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pap_fifo #(
    parameter int W     = 33,
    parameter int DEPTH = 8
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   count_r;
    logic          push;
    logic          pop;

    assign in_ready  = (count_r != FULL_CNT);
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: pap_phase_term.sv
`timescale 1ns/1ps
`default_nettype none
module pap_phase_term (
    input  wire logic                                core_clk,
    input  wire logic                                nrst,
    input  wire logic                                adv1,
    input  wire logic                                adv2,
    input  wire logic                                adv3,
    input  wire logic signed [pap_pkg::SAMP_W-1:0]   volt,
    input  wire logic signed [pap_pkg::CUR_W-1:0]    cur,
    input  wire logic signed [pap_pkg::GAIN_W-1:0]   offset,
    input  wire logic signed [pap_pkg::GAIN_W-1:0]   watt_gain,
    output logic signed      [pap_pkg::TERM_W-1:0]   term
);
    localparam int PFULL_W = pap_pkg::SAMP_W + pap_pkg::CUR_W;
    localparam int SUM_W   = pap_pkg::BUS_W + 1;
    localparam int WFULL_W = SUM_W + pap_pkg::GMUL_W;

    logic signed [PFULL_W-1:0]          pfull;
    logic signed [pap_pkg::BUS_W-1:0]   prod_r;
    logic signed [pap_pkg::BUS_W-1:0]   lpf_r;
    logic signed [SUM_W-1:0]            lpf_diff;
    logic signed [SUM_W-1:0]            lpf_step;
    logic signed [SUM_W-1:0]            ofs_sum;
    logic signed [pap_pkg::GMUL_W-1:0]  wmul;
    logic signed [WFULL_W-1:0]          wfull;

    assign pfull    = volt * cur;
    assign lpf_diff = SUM_W'(prod_r) - SUM_W'(lpf_r);
    assign lpf_step = lpf_diff >>> pap_pkg::LPF_SHIFT;
    assign ofs_sum  = SUM_W'(lpf_r) + SUM_W'(offset);
    assign wmul     = pap_pkg::GMUL_W'(watt_gain) + pap_pkg::GAIN_UNITY;
    assign wfull    = ofs_sum * wmul;

    // Bus keeps top bits; dropped LSBs are below offset weight
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prod_r <= '0;
        end else if (adv1) begin
            prod_r <= pfull[pap_pkg::PROD_SHIFT+pap_pkg::BUS_W-1:pap_pkg::PROD_SHIFT];
        end
    end

    // First-order smoothing; ripple left for the integrator
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lpf_r <= '0;
        end else if (adv2) begin
            lpf_r <= lpf_r + lpf_step[pap_pkg::BUS_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            term <= '0;
        end else if (adv3) begin
            term <= wfull[pap_pkg::GAIN_FRAC+pap_pkg::TERM_W-1:pap_pkg::GAIN_FRAC];
        end
    end
endmodule
`default_nettype wire

// file: pap_power_sum.sv
`timescale 1ns/1ps
`default_nettype none
module pap_power_sum (
    input  wire logic                                core_clk,
    input  wire logic                                nrst,
    input  wire logic                                sample_valid,
    output logic                                     sample_ready,
    input  wire logic signed [pap_pkg::SAMP_W-1:0]   volt_a,
    input  wire logic signed [pap_pkg::SAMP_W-1:0]   volt_b,
    input  wire logic signed [pap_pkg::SAMP_W-1:0]   volt_c,
    input  wire logic signed [pap_pkg::SAMP_W-1:0]   cur_a,
    input  wire logic signed [pap_pkg::SAMP_W-1:0]   cur_b,
    input  wire logic signed [pap_pkg::SAMP_W-1:0]   cur_c,
    input  wire logic                                reg_wr_en,
    input  wire logic                                reg_rd_en,
    input  wire logic        [pap_pkg::REG_AW-1:0]   reg_addr,
    input  wire logic        [pap_pkg::REG_DW-1:0]   reg_wr_data,
    output logic             [pap_pkg::REG_DW-1:0]   reg_rd_data,
    output logic                                     power_valid,
    input  wire logic                                power_ready,
    output logic signed      [pap_pkg::TOTAL_W-1:0]  power_data,
    output logic             [pap_pkg::EOUT_W-1:0]   energy_upper
);
    localparam int GFULL_W = pap_pkg::SAMP_W + pap_pkg::GMUL_W;

    logic signed [pap_pkg::GAIN_W-1:0]     ofs_r [3];
    logic signed [pap_pkg::GAIN_W-1:0]     pgain_r [3];
    logic signed [pap_pkg::GAIN_W-1:0]     watt_gain_r [3];
    logic        [pap_pkg::MODE_REG_W-1:0] mode_reg_r;
    logic        [pap_pkg::NUM_W-1:0]      numer_r;
    logic        [2:0]                     rev_r;
    logic        [2:0]                     rev_nxt;
    logic        [pap_pkg::REG_DW-1:0]     rd_nxt;
    logic signed [pap_pkg::ACC_W-1:0]      acc_r;

    pap_pkg::pap_mode_t                    mode;
    logic                                  en_a;
    logic                                  en_b;
    logic                                  en_c;

    logic signed [pap_pkg::SAMP_W-1:0]     cur_in [3];
    logic signed [pap_pkg::CUR_W-1:0]      cur_sc [3];
    logic signed [pap_pkg::CUR_W-1:0]      sel_a;
    logic signed [pap_pkg::CUR_W-1:0]      sel_c;

    logic signed [pap_pkg::CUR_W-1:0]      cur_a_r;
    logic signed [pap_pkg::CUR_W-1:0]      cur_b_r;
    logic signed [pap_pkg::CUR_W-1:0]      cur_c_r;
    logic signed [pap_pkg::SAMP_W-1:0]     volt_a_r;
    logic signed [pap_pkg::SAMP_W-1:0]     volt_b_r;
    logic signed [pap_pkg::SAMP_W-1:0]     volt_c_r;

    logic        [3:0]                     vld_r;
    logic                                  adv;
    logic                                  push;
    logic                                  pop;

    logic signed [pap_pkg::TERM_W-1:0]     term_a;
    logic signed [pap_pkg::TERM_W-1:0]     term_b;
    logic signed [pap_pkg::TERM_W-1:0]     term_c;
    logic signed [pap_pkg::TOTAL_W-1:0]    total;
    logic                                  fifo_in_ready;

    assign mode = pap_pkg::pap_mode_t'(mode_reg_r[pap_pkg::MODE_MSB:pap_pkg::MODE_LSB]);
    assign en_a = mode_reg_r[pap_pkg::EN_A_BIT];
    assign en_b = mode_reg_r[pap_pkg::EN_B_BIT];
    assign en_c = mode_reg_r[pap_pkg::EN_C_BIT];

    assign cur_in[0] = cur_a;
    assign cur_in[1] = cur_b;
    assign cur_in[2] = cur_c;

    // Whole pipe stalls together when the FIFO is full
    assign adv          = fifo_in_ready;
    assign sample_ready = fifo_in_ready;
    assign push         = adv && vld_r[3];
    assign pop          = power_valid && power_ready;

    always_comb begin
        logic signed [pap_pkg::GMUL_W-1:0] gmul;
        logic signed [GFULL_W-1:0]         gfull;

        gmul  = '0;
        gfull = '0;

        for (int p = 0; p < 3; p++) begin
            gmul      = pap_pkg::GMUL_W'(pgain_r[p]) + pap_pkg::GAIN_UNITY;
            gfull     = cur_in[p] * gmul;
            cur_sc[p] = gfull[pap_pkg::GAIN_FRAC+pap_pkg::CUR_W-1:pap_pkg::GAIN_FRAC];
        end
    end

    // Current per term by formula
    always_comb begin
        sel_a = cur_sc[0];
        sel_c = cur_sc[2];

        unique case (mode)
            pap_pkg::PAP_DIFF_AC: begin
                sel_a = cur_sc[0] - cur_sc[1];
                sel_c = cur_sc[2] - cur_sc[1];
            end

            pap_pkg::PAP_DIFF_A: begin
                sel_a = cur_sc[0] - cur_sc[1];
                sel_c = cur_sc[2];
            end

            pap_pkg::PAP_SUM3, pap_pkg::PAP_RSVD: begin
                sel_a = cur_sc[0];
                sel_c = cur_sc[2];
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vld_r <= '0;
        end else if (adv) begin
            vld_r <= {vld_r[2:0], sample_valid};
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cur_a_r  <= '0;
            cur_b_r  <= '0;
            cur_c_r  <= '0;

            volt_a_r <= '0;
            volt_b_r <= '0;
            volt_c_r <= '0;
        end else if (adv && sample_valid) begin
            cur_a_r  <= sel_a;
            cur_b_r  <= cur_sc[1];
            cur_c_r  <= sel_c;

            volt_a_r <= volt_a;
            volt_b_r <= volt_b;
            volt_c_r <= volt_c;
        end
    end

    pap_phase_term u_term_a (
        .core_clk (core_clk),
        .nrst     (nrst),
        .adv1     (adv && vld_r[0]),
        .adv2     (adv && vld_r[1]),
        .adv3     (adv && vld_r[2]),
        .volt     (volt_a_r),
        .cur      (cur_a_r),
        .offset   (ofs_r[0]),
        .watt_gain    (watt_gain_r[0]),
        .term     (term_a)
    );

    // Phase B product kept for its flag even when a difference mode drops it from the total
    pap_phase_term u_term_b (
        .core_clk (core_clk),
        .nrst     (nrst),
        .adv1     (adv && vld_r[0]),
        .adv2     (adv && vld_r[1]),
        .adv3     (adv && vld_r[2]),
        .volt     (volt_b_r),
        .cur      (cur_b_r),
        .offset   (ofs_r[1]),
        .watt_gain    (watt_gain_r[1]),
        .term     (term_b)
    );

    pap_phase_term u_term_c (
        .core_clk (core_clk),
        .nrst     (nrst),
        .adv1     (adv && vld_r[0]),
        .adv2     (adv && vld_r[1]),
        .adv3     (adv && vld_r[2]),
        .volt     (volt_c_r),
        .cur      (cur_c_r),
        .offset   (ofs_r[2]),
        .watt_gain    (watt_gain_r[2]),
        .term     (term_c)
    );

    always_comb begin
        logic b_used;

        b_used = (mode == pap_pkg::PAP_SUM3) || (mode == pap_pkg::PAP_RSVD);
        total  = '0;

        if (en_a) begin
            total = total + pap_pkg::TOTAL_W'(term_a);
        end
        if (en_b && b_used) begin
            total = total + pap_pkg::TOTAL_W'(term_b);
        end
        if (en_c) begin
            total = total + pap_pkg::TOTAL_W'(term_c);
        end
    end

    pap_fifo #(
        .W     (pap_pkg::TOTAL_W),
        .DEPTH (pap_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .in_valid  (vld_r[3]),
        .in_ready  (fifo_in_ready),
        .in_data   (total),
        .out_valid (power_valid),
        .out_ready (power_ready),
        .out_data  (power_data)
    );

    always_comb begin
        rev_nxt = rev_r;
        if (push) begin
            rev_nxt = {term_c[pap_pkg::TERM_W-1], term_b[pap_pkg::TERM_W-1], term_a[pap_pkg::TERM_W-1]};
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rev_r <= '0;
        end else begin
            rev_r <= rev_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            acc_r <= '0;
        end else if (pop) begin
            acc_r <= acc_r + pap_pkg::ACC_W'(power_data);
        end
    end

    assign energy_upper = acc_r[pap_pkg::ACC_W-1:pap_pkg::ACC_W-pap_pkg::EOUT_W];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < 3; p++) begin
                ofs_r[p]   <= pap_pkg::OFS_RESET;
                pgain_r[p] <= pap_pkg::GAIN_RESET;
                watt_gain_r[p] <= pap_pkg::GAIN_RESET;
            end

            mode_reg_r <= pap_pkg::MODE_RESET;
            numer_r    <= pap_pkg::NUM_RESET;
        end else if (reg_wr_en) begin
            unique case (reg_addr)
                pap_pkg::ADDR_OFS_A: ofs_r[0]   <= reg_wr_data[pap_pkg::GAIN_W-1:0];
                pap_pkg::ADDR_OFS_B: ofs_r[1]   <= reg_wr_data[pap_pkg::GAIN_W-1:0];
                pap_pkg::ADDR_OFS_C: ofs_r[2]   <= reg_wr_data[pap_pkg::GAIN_W-1:0];

                pap_pkg::ADDR_PG_A:  pgain_r[0] <= reg_wr_data[pap_pkg::GAIN_W-1:0];
                pap_pkg::ADDR_PG_B:  pgain_r[1] <= reg_wr_data[pap_pkg::GAIN_W-1:0];
                pap_pkg::ADDR_PG_C:  pgain_r[2] <= reg_wr_data[pap_pkg::GAIN_W-1:0];

                pap_pkg::ADDR_WG_A:  watt_gain_r[0] <= reg_wr_data[pap_pkg::GAIN_W-1:0];
                pap_pkg::ADDR_WG_B:  watt_gain_r[1] <= reg_wr_data[pap_pkg::GAIN_W-1:0];
                pap_pkg::ADDR_WG_C:  watt_gain_r[2] <= reg_wr_data[pap_pkg::GAIN_W-1:0];

                pap_pkg::ADDR_MODE:  mode_reg_r <= reg_wr_data[pap_pkg::MODE_REG_W-1:0];
                pap_pkg::ADDR_NUMER: numer_r    <= reg_wr_data[pap_pkg::NUM_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_nxt = '0;

        unique case (reg_addr)
            pap_pkg::ADDR_OFS_A: rd_nxt = pap_pkg::REG_DW'(unsigned'(ofs_r[0]));
            pap_pkg::ADDR_OFS_B: rd_nxt = pap_pkg::REG_DW'(unsigned'(ofs_r[1]));
            pap_pkg::ADDR_OFS_C: rd_nxt = pap_pkg::REG_DW'(unsigned'(ofs_r[2]));

            pap_pkg::ADDR_PG_A:  rd_nxt = pap_pkg::REG_DW'(unsigned'(pgain_r[0]));
            pap_pkg::ADDR_PG_B:  rd_nxt = pap_pkg::REG_DW'(unsigned'(pgain_r[1]));
            pap_pkg::ADDR_PG_C:  rd_nxt = pap_pkg::REG_DW'(unsigned'(pgain_r[2]));

            pap_pkg::ADDR_WG_A:  rd_nxt = pap_pkg::REG_DW'(unsigned'(watt_gain_r[0]));
            pap_pkg::ADDR_WG_B:  rd_nxt = pap_pkg::REG_DW'(unsigned'(watt_gain_r[1]));
            pap_pkg::ADDR_WG_C:  rd_nxt = pap_pkg::REG_DW'(unsigned'(watt_gain_r[2]));

            pap_pkg::ADDR_MODE:  rd_nxt = pap_pkg::REG_DW'(mode_reg_r);
            pap_pkg::ADDR_NUMER: begin
                rd_nxt = pap_pkg::REG_DW'(numer_r);

                rd_nxt[pap_pkg::REV_A_BIT] = rev_r[0] && en_a;
                rd_nxt[pap_pkg::REV_B_BIT] = rev_r[1] && en_b;
                rd_nxt[pap_pkg::REV_C_BIT] = rev_r[2] && en_c;
            end
            default: rd_nxt = '0;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rd_data <= '0;
        end else if (reg_rd_en) begin
            reg_rd_data <= rd_nxt;
        end
    end
endmodule
`default_nettype wire

// file: pap_power_sum_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pap_power_sum_props (
    input  wire logic                               core_clk,
    input  wire logic                               nrst,
    input  wire logic                               sample_valid,
    input  wire logic                               sample_ready,
    input  wire logic                               reg_wr_en,
    input  wire logic                               reg_rd_en,
    input  wire logic        [pap_pkg::REG_AW-1:0]  reg_addr,
    input  wire logic        [pap_pkg::REG_DW-1:0]  reg_wr_data,
    input  wire logic        [pap_pkg::REG_DW-1:0]  reg_rd_data,
    input  wire logic                               power_valid,
    input  wire logic                               power_ready,
    input  wire logic signed [pap_pkg::TOTAL_W-1:0] power_data,
    input  wire logic        [pap_pkg::EOUT_W-1:0]  energy_upper
);
    logic [11:0] sh_r [0:10];
    logic [15:0] exp_r;
    logic [2:0]  mask_r;
    logic [53:0] acc_r;
    logic        pop;
    assign pop = power_valid && power_ready;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int k = 0; k <= 10; k++)
                sh_r[k] <= 12'h000;
            sh_r[3] <= {4'h0, pap_pkg::MODE_RESET};
        end else if (reg_wr_en && reg_addr <= 4'ha) begin
            sh_r[reg_addr] <= (reg_addr == 4'h3) ? {4'h0, reg_wr_data[7:0]} : reg_wr_data[11:0];
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            exp_r <= 16'h0000;
            mask_r <= 3'h0;
        end else begin
            exp_r <= (reg_addr <= 4'ha) ? {4'h0, sh_r[reg_addr]} : 16'h0000;
            mask_r <= {sh_r[3][3], sh_r[3][4], sh_r[3][5]};
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            acc_r <= 54'h0;
        else if (pop)
            acc_r <= acc_r + 54'(power_data);
    end
    sequence s_take_empty;
        sample_valid && sample_ready && !power_valid;
    endsequence
    sequence s_word_out;
        ##5 power_valid;
    endsequence
    property p_energy_match;
        !pop && !$past(pop) |-> energy_upper == acc_r[53:30];
    endproperty
    a_reg_readback: assert property (reg_rd_en && reg_addr != 4'ha |=> reg_rd_data == exp_r)
        else $error("readback mismatch");
    a_numer_low: assert property (reg_rd_en && reg_addr == 4'ha |=> reg_rd_data[11:0] == exp_r[11:0] && !reg_rd_data[15])
        else $error("numerator mismatch");
    a_flag_masked: assert property (reg_rd_en && reg_addr == 4'ha |=> (reg_rd_data[14:12] & ~mask_r) == 3'h0)
        else $error("disabled phase flag set");
    a_mode_write_read: assert property (reg_wr_en && reg_addr == 4'h3 ##1 reg_rd_en && reg_addr == 4'h3
        |=> reg_rd_data[7:0] == $past(reg_wr_data[7:0], 2))
        else $error("mode write not seen");
    a_empty_ready: assert property (!power_valid |-> sample_ready)
        else $error("refused while queue empty");
    a_stall_hold: assert property (power_valid && !power_ready |=> power_valid && $stable(power_data))
        else $error("word lost under stall");
    a_push_latency: assert property (s_take_empty |-> s_word_out)
        else $error("total word late");
    a_energy_track: assert property (p_energy_match)
        else $error("energy sum mismatch");
endmodule
bind pap_power_sum pap_power_sum_props u_pap_power_sum_props (.core_clk(core_clk), .nrst(nrst),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .power_valid(power_valid),
    .power_ready(power_ready), .power_data(power_data), .energy_upper(energy_upper));
`default_nettype wire

// file: pap_sink.sv
`timescale 1ns/1ps
`default_nettype none
module pap_sink (
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire logic               stall,
    input  wire logic               power_valid,
    input  wire logic signed [32:0] power_data,
    output logic                    power_ready,
    output logic             [23:0] acc_upper
);
    logic signed [53:0] acc_r;
    assign power_ready = !stall;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            acc_r <= 54'h0;
        else if (power_valid && power_ready)
            acc_r <= acc_r + 54'(power_data);
    end
    assign acc_upper = acc_r[53:30];
endmodule
`default_nettype wire

// file: tb_pap_power_sum.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t: %h vs %h", $time, a, b); end end
module tb_pap_power_sum;
    logic               core_clk, nrst, sample_valid, sample_ready, reg_wr_en, reg_rd_en;
    logic               stall, power_valid, power_ready;
    logic signed [15:0] v [3];
    logic signed [15:0] c [3];
    logic [3:0]         reg_addr;
    logic [15:0]        reg_wr_data, reg_rd_data;
    logic signed [32:0] power_data;
    logic [23:0]        energy_upper, acc_upper;
    logic signed [32:0] got [$];
    logic signed [32:0] want [$];
    longint             lpf [3], ofs [3], pg [3], wg [3];
    logic [7:0]         mode;
    logic [2:0]         flag;
    int                 num_errors = 0;
    int                 checks = 0;
    int                 cyc = 0;
    pap_power_sum u_pap_power_sum (.core_clk(core_clk), .nrst(nrst), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .volt_a(v[0]), .volt_b(v[1]), .volt_c(v[2]), .cur_a(c[0]), .cur_b(c[1]),
        .cur_c(c[2]), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .power_valid(power_valid),
        .power_ready(power_ready), .power_data(power_data), .energy_upper(energy_upper));
    pap_sink u_pap_sink (.core_clk(core_clk), .nrst(nrst), .stall(stall), .power_valid(power_valid),
        .power_data(power_data), .power_ready(power_ready), .acc_upper(acc_upper));
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (nrst && power_valid && power_ready)
            got.push_back(power_data);
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict;
        end
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic do_reset;
        nrst = 0;
        repeat (3) @(posedge core_clk) #1;
        nrst = 1;
        mode = 8'h38;
        for (int j = 0; j < 3; j++) begin
            lpf[j] = 0;
            ofs[j] = 0;
            pg[j] = 0;
            wg[j] = 0;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk) #1;
        reg_wr_en = 1;
        reg_addr = a;
        reg_wr_data = d;
        @(posedge core_clk) #1;
        reg_wr_en = 0;
        if (a < 3) ofs[a] = $signed(d[11:0]);
        else if (a == 3) mode = d[7:0];
        else if (a < 7) pg[a-4] = $signed(d[11:0]);
        else if (a < 10) wg[a-7] = $signed(d[11:0]);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        reg_rd_en = 1;
        reg_addr = a;
        @(posedge core_clk) #1;
        reg_rd_en = 0;
        @(posedge core_clk) #1;
        `CHK(reg_rd_data, e) // read value
    endtask
    task automatic model(input int n);
        longint ci [3], p, t;
        logic dif;
        dif = mode[7:6] == 2'h1 || mode[7:6] == 2'h2;
        for (int j = 0; j < 3; j++)
            ci[j] = (c[j] * (4096 + pg[j])) >>> 12;
        for (int k = 0; k < n; k++) begin
            t = 0;
            for (int j = 0; j < 3; j++) begin
                p = v[j] * (ci[j] - ((dif && (j == 0 || (j == 2 && mode[7:6] == 2'h1))) ? ci[1] : 0));
                lpf[j] += ((p >>> 6) - lpf[j]) >>> 4;
                p = ((lpf[j] + ofs[j]) * (4096 + wg[j])) >>> 12;
                flag[j] = p < 0;
                if (mode[5-j] && !(j == 1 && dif)) t += p;
            end
            want.push_back(t);
        end
    endtask
    task automatic run(input int n);
        model(n);
        sample_valid = 1;
        for (int k = 0; k < n; k++) begin
            while (!sample_ready) @(posedge core_clk) #1;
            @(posedge core_clk) #1;
        end
        sample_valid = 0;
        for (int k = 0; k < 300 && got.size() < want.size(); k++) @(posedge core_clk) #1;
        repeat (3) @(posedge core_clk) #1;
        `CHK(got.size(), want.size()) // word count
        foreach (want[k]) `CHK(got[k], want[k]) // total word
        `CHK(energy_upper, acc_upper) // energy sum
        got.delete();
        want.delete();
    endtask
    task automatic chk_flags;
        rd(4'ha, {1'b0, flag[2] & mode[3], flag[1] & mode[4], flag[0] & mode[5], 12'h000}); // sign flags
    endtask
    task automatic t_regs;
        rd(4'h3, 16'h0038); // mode reset
        rd(4'h0, 16'h0000); // offset reset
        wr(4'h0, 16'hf800);
        rd(4'h0, 16'h0800); // upper bits zero
        wr(4'h3, 16'hffc8);
        rd(4'h3, 16'h00c8); // mode field
        wr(4'ha, 16'hffff);
        rd(4'ha, 16'h0fff); // read-only flags
        rd(4'hf, 16'h0000);
        $display("test regs done");
    endtask
    task automatic t_offset;
        wr(4'h0, 16'h07ff);
        wr(4'h1, 16'h0800);
        wr(4'h2, 16'h0001);
        wr(4'h7, 16'h07ff);
        wr(4'h9, 16'h0800);
        run(3); // offset added
        chk_flags; // flag bits
        wr(4'h3, 16'h0028);
        run(2); // term dropped
        chk_flags; // flag forced low
        $display("test offset done");
    endtask
    task automatic t_modes;
        logic [7:0] tbl [8] = '{8'h38, 8'h68, 8'ha8, 8'hf8, 8'h18, 8'h30, 8'h78, 8'hb0};
        for (int i = 0; i < 8; i++) begin
            do_reset;
            if (tbl[i][7] ^ tbl[i][6]) begin
                wr(4'h4, 16'h07ff);
                wr(4'h5, 16'h0800);
                wr(4'h6, 16'h0100);
            end
            wr(4'h8, 16'h07ff);
            wr(4'h3, {8'h00, tbl[i]});
            run(6);
            chk_flags; // flags per mode
        end
        $display("test modes done");
    endtask
    task automatic t_full;
        do_reset;
        stall = 1;
        fork
            run(14); // queued words
            begin
                wait (sample_ready === 1'b0);
                `CHK(power_valid, 1'b1) // queue full
                @(posedge core_clk) #1;
                stall = 0;
            end
        join
        `CHK(power_valid, 1'b0) // drained
        $display("test full done");
    endtask
    initial begin
        sample_valid = 0;
        reg_wr_en = 0;
        reg_rd_en = 0;
        reg_addr = 4'h0;
        reg_wr_data = 16'h0000;
        stall = 0;
        v = '{16'sh0000, 16'sh0000, 16'sh0000};
        c = '{16'sh0000, 16'sh0000, 16'sh0000};
        do_reset;
        t_regs;
        do_reset;
        t_offset;
        v = '{16'sh0bb8, -16'sh07d0, 16'sh05dc};
        c = '{16'sh0fa0, 16'sh09c4, -16'sh0bb8};
        t_modes;
        t_full;
        give_verdict;
    end
endmodule
`default_nettype wire
